// file: logic/adc_constant_trigger_program.sv
`timescale 1ns/1ns
module adc_constant_trigger_program
  import adc_const_trig_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   convReq,
  output logic      [SEL_W-1:0]  convChannel,
  output logic      [IDX_W-1:0]  convSlot,
  input  wire logic              convAck
);

  logic       [SLOT_W-1:0] slot      [NUM_SLOTS];
  logic       [SLOT_W-1:0] next_slot [NUM_SLOTS];
  logic       [DATA_W-1:0] next_prdata;
  logic                    next_pready;
  logic                    next_pslverr;
  seq_state_t              state;
  seq_state_t              next_state;
  logic       [IDX_W-1:0]  idx;
  logic       [IDX_W-1:0]  next_idx;
  logic                    next_convReq;
  logic       [SEL_W-1:0]  next_convChannel;
  logic       [IDX_W-1:0]  next_convSlot;

  function automatic logic slotLive(input logic [SLOT_W-1:0] s);
    logic [SEL_W-1:0] sel;
    sel = s[SEL_LSB +: SEL_W];
    return s[ENABLE_BIT] && sel >= SEL_MIN && sel <= SEL_MAX;
  endfunction : slotLive

  function automatic logic [IDX_W-1:0] nextIdx(input logic [IDX_W-1:0] i);
    return (i == IDX_LAST) ? IDX_FIRST : IDX_W'(i + 1'b1);
  endfunction : nextIdx

  function automatic logic [ADDR_W-1:0] regAddr(input int k);
    return ADDR_W'(OFF_SLOTS_0_3 + REG_STRIDE * k);
  endfunction : regAddr

  ////////////////////////////////////////////////////////////////////////////
  // register file over apb, one wait state

  always_comb begin
    logic wrEdge;
    logic hit;
    wrEdge       = psel && penable && pready && pwrite && !pslverr;
    hit          = 1'b0;
    next_pready  = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata  = prdata;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      next_slot[s] = slot[s];
    end
    for (int k = 0; k < NUM_REGS; k++) begin
      if (wrEdge && paddr == regAddr(k)) begin
        for (int b = 0; b < SLOTS_PER_REG; b++) begin
          // reserved bits dropped on write
          next_slot[k*SLOTS_PER_REG+b] =
            pwdata[b*SLOT_W +: SLOT_W] & SLOT_MASK;
        end
      end
    end
    if (psel && penable && !pready) begin
      next_prdata = '0;
      for (int k = 0; k < NUM_REGS; k++) begin
        if (paddr == regAddr(k)) begin
          hit = 1'b1;
          for (int b = 0; b < SLOTS_PER_REG; b++) begin
            next_prdata[b*SLOT_W +: SLOT_W] =
              slot[k*SLOTS_PER_REG+b];
          end
        end
      end
      if (paddr == OFF_STATUS) begin
        hit = 1'b1;
        if (!pwrite) begin
          next_prdata[STAT_BUSY_BIT]           = (state == WAIT);
          next_prdata[STAT_IDX_LSB +: IDX_W]   = idx;
        end
      end
      next_pslverr = !hit || (pwrite && paddr == OFF_STATUS);
      if (pwrite || !hit) begin
        next_prdata = '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        slot[s] <= SLOT_RESET;
      end
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        slot[s] <= next_slot[s];
      end
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // constant trigger scanner, skips a dead slot per cycle, holds a live one until convAck

  always_comb begin
    next_state       = state;
    next_idx         = idx;
    next_convReq     = convReq;
    next_convChannel = convChannel;
    next_convSlot    = convSlot;
    case (state)
      SCAN: begin
        // no start event needed: scanning runs from reset and only pauses in WAIT until convAck
        if (slotLive(slot[idx])) begin
          next_convReq     = 1'b1;
          next_convChannel = slot[idx][SEL_LSB +: SEL_W];
          next_convSlot    = idx;
          next_state       = WAIT;
        end else begin
          next_idx = nextIdx(idx);
        end
      end
      WAIT: begin
        if (convAck) begin
          next_convReq = 1'b0;
          next_idx     = nextIdx(idx);
          next_state   = SCAN;
        end
      end
      default: begin
        next_state   = SCAN;
        next_convReq = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state       <= SCAN;
      idx         <= IDX_FIRST;
      convReq     <= 1'b0;
      convChannel <= '0;
      convSlot    <= '0;
    end else begin
      state       <= next_state;
      idx         <= next_idx;
      convReq     <= next_convReq;
      convChannel <= next_convChannel;
      convSlot    <= next_convSlot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_req_needs_enable: assert property (
    $rose(convReq) |-> $past(slot[idx][ENABLE_BIT]))
    else $error("request from a disabled slot");

  a_chan_from_slot: assert property (
    $rose(convReq) |-> convChannel == $past(slot[idx][SEL_LSB +: SEL_W]))
    else $error("channel differs from slot selector");

  a_code_legal: assert property (
    convReq |-> convChannel >= SEL_MIN && convChannel <= SEL_MAX)
    else $error("reserved selector code requested");

  a_slot_index_range: assert property (
    idx <= IDX_LAST && convSlot <= IDX_LAST)
    else $error("slot index out of range");

  a_req_holds: assert property (
    convReq && !convAck |=> convReq && $stable(convSlot)
      && $stable(convChannel))
    else $error("request dropped before acknowledge");

  a_req_slot_index: assert property (
    $rose(convReq) |-> convSlot == idx)
    else $error("result index differs from slot index");

  a_trigger_live: assert property (
    state == SCAN && slotLive(slot[idx]) |=> convReq)
    else $error("live slot did not trigger");

  a_reserved_zero: assert property (
    pready && !pwrite |-> (prdata & RSV_MASK) == '0)
    else $error("reserved bits read nonzero");

  a_reset_clear: assert property (
    disable iff (1'b0)
    $past(rst) |-> slot[IDX_FIRST] == SLOT_RESET
      && slot[IDX_LAST] == SLOT_RESET && !convReq)
    else $error("state not cleared by reset");

  // bus side
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held for more than one cycle");

  a_ready_after_access: assert property (
    psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");

  a_no_stray_ready: assert property (
    !psel |=> !pready)
    else $error("ready without a selected transfer");

  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("error flag outside the answer cycle");

  a_err_data_zero: assert property (
    pready && pslverr |-> prdata == '0)
    else $error("refused transfer returned data");

  a_status_write_err: assert property (
    pready && pwrite && paddr == OFF_STATUS |-> pslverr)
    else $error("write to status word not refused");

  a_unmapped_err: assert property (
    pready && paddr > OFF_STATUS |-> pslverr)
    else $error("unmapped address not refused");

  a_write_low_slot: assert property (
    pready && pwrite && !pslverr && paddr == OFF_SLOTS_0_3
      |=> slot[IDX_FIRST] == ($past(pwdata[SLOT_W-1:0]) & SLOT_MASK))
    else $error("write missed the first slot");

  a_write_high_slot: assert property (
    pready && pwrite && !pslverr && paddr == OFF_SLOTS_8_11
      |=> slot[IDX_LAST] == ($past(pwdata[DATA_W-1 -: SLOT_W]) & SLOT_MASK))
    else $error("write missed the last slot");

  a_read_first_slot: assert property (
    pready && !pwrite && !pslverr && paddr == OFF_SLOTS_0_3
      |-> prdata[SLOT_W-1:0] == slot[IDX_FIRST])
    else $error("first slot read back wrong");

  a_read_last_slot: assert property (
    pready && !pwrite && !pslverr && paddr == OFF_SLOTS_8_11
      |-> prdata[DATA_W-1 -: SLOT_W] == slot[IDX_LAST])
    else $error("last slot read back wrong");

  a_read_no_store: assert property (
    pready && !pwrite |=> slot[IDX_FIRST] == $past(slot[IDX_FIRST]))
    else $error("read disturbed a slot");

  a_status_read: assert property (
    pready && !pwrite && paddr == OFF_STATUS
      |-> prdata[STAT_BUSY_BIT] == $past(state == WAIT))
    else $error("status busy bit wrong");

  // scanner side
  a_slot_rsv_low: assert property (
    (slot[idx] & ~SLOT_MASK) == '0)
    else $error("reserved slot bits stored");

  a_busy_is_req: assert property (
    convReq == (state == WAIT))
    else $error("request flag and scanner state disagree");

  a_ack_releases: assert property (
    convReq && convAck |=> !convReq)
    else $error("request held after acknowledge");

  a_skip_dead: assert property (
    state == SCAN && !slotLive(slot[idx])
      |=> !convReq && idx == nextIdx($past(idx)))
    else $error("dead slot not skipped");

  a_idx_holds_wait: assert property (
    state == WAIT && !convAck |=> $stable(idx))
    else $error("scan index moved during a request");

  a_idx_after_ack: assert property (
    convReq && convAck |=> idx == nextIdx($past(idx)))
    else $error("scan did not advance after acknowledge");

  a_disabled_idle: assert property (
    state == SCAN && !slot[idx][ENABLE_BIT] |=> !convReq)
    else $error("disabled slot raised a request");

  a_reserved_idle: assert property (
    state == SCAN && (slot[idx][SEL_LSB +: SEL_W] < SEL_MIN
      || slot[idx][SEL_LSB +: SEL_W] > SEL_MAX) |=> !convReq)
    else $error("reserved selector code raised a request");

  c_conv_done: cover property (convReq && convAck);
  c_wrap_scan: cover property ($rose(convReq) && convSlot == IDX_LAST);
  c_bad_addr: cover property (pready && pslverr);
  c_slot_write: cover property (pready && pwrite && !pslverr);
  c_skip_reserved: cover property (state == SCAN
    && slot[idx][ENABLE_BIT] && !slotLive(slot[idx]));

endmodule : adc_constant_trigger_program

// file: pkg/adc_const_trig_pkg.sv
package adc_const_trig_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          NUM_SLOTS     = 12;
  localparam int          SLOTS_PER_REG = 4;
  localparam int          SLOT_W        = 8;
  localparam int          SEL_W         = 5;
  localparam int          IDX_W         = 4;
  localparam int          NUM_REGS      = 3;
  // register byte addresses
  localparam logic [11:0] OFF_SLOTS_0_3  = 12'h000;
  localparam logic [11:0] OFF_SLOTS_4_7  = 12'h004;
  localparam logic [11:0] OFF_SLOTS_8_11 = 12'h008;
  localparam logic [11:0] OFF_STATUS     = 12'h00c;
  localparam logic [11:0] REG_STRIDE     = 12'h004;
  // slot byte layout
  localparam int          ENABLE_BIT    = 7;
  localparam int          SEL_LSB       = 0;
  localparam logic [7:0]  SLOT_MASK     = 8'h9f;
  localparam logic [7:0]  SLOT_RESET    = 8'h00;
  localparam logic [31:0] RSV_MASK      = 32'h60606060;
  // legal selector codes, channel 2 to channel 12
  localparam logic [4:0]  SEL_MIN       = 5'h02;
  localparam logic [4:0]  SEL_MAX       = 5'h0c;
  // status word layout
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_IDX_LSB  = 8;
  localparam logic [3:0]  IDX_LAST      = 4'hb;
  localparam logic [3:0]  IDX_FIRST     = 4'h0;

  typedef enum logic {SCAN, WAIT} seq_state_t;
endpackage : adc_const_trig_pkg

// file: tb/adc_constant_trigger_program_test.sv
`timescale 1ns/1ns
module adc_constant_trigger_program_test;
  import adc_const_trig_pkg::*;
  logic              ref_clk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              convReq;
  logic [SEL_W-1:0]  convChannel;
  logic [IDX_W-1:0]  convSlot;
  logic              convAck;
  logic [7:0]        cfg [NUM_SLOTS];
  integer            seed;
  int                badCount;
  int                checked;
  int                prev;
  int                nxt;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] w;
  logic              err;
  logic [3:0]        gotSlot;
  logic [4:0]        gotCh;

  adc_constant_trigger_program dut (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convReq(convReq), .convChannel(convChannel), .convSlot(convSlot),
    .convAck(convAck));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  function automatic bit live(int k);
    return cfg[k][7] && cfg[k][4:0] >= 5'h02 && cfg[k][4:0] <= 5'h0c;
  endfunction : live

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // compares the last served grant with the model's slot s
  task automatic chkGrant(input int s);
    chk(32'(gotSlot), 32'(s), "slot order");
    chk(32'(gotCh), 32'(cfg[s][4:0]), "channel");
  endtask : chkGrant

  task automatic apb(input logic [11:0] a, input logic wr,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic doReset();
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (cfg[k]) cfg[k] = 8'h00;
    @(posedge ref_clk);
  endtask : doReset

  task automatic checkRegs();
    for (int r = 0; r < 3; r++) begin
      apb(12'(r * 4), 1'b0, 32'h0);
      chk(rd, {cfg[4*r+3], cfg[4*r+2], cfg[4*r+1], cfg[4*r]}, "readback");
    end
  endtask : checkRegs

  // waits for a request, takes slot and channel, acks for one edge
  task automatic serve();
    do @(posedge ref_clk); while (convReq !== 1'b1);
    gotSlot = convSlot;
    gotCh = convChannel;
    convAck <= 1'b1;
    @(posedge ref_clk);
    convAck <= 1'b0;
  endtask : serve

  task automatic wrapUp();
    $display("mismatches %0d comparisons %0d", badCount, checked);
    if (badCount == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrapUp

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    badCount++;
    wrapUp();
  end

  initial begin
    seed = 32'h95b0;
    {rst, psel, penable, pwrite, convAck} = 5'b10000;
    paddr = 12'h000;
    pwdata = 32'h0;
    badCount = 0;
    checked = 0;
    doReset();
    checkRegs();
    for (int r = 0; r < 3; r++) begin
      w = $random(seed);
      if (r == 0) w[7:0] = 8'he2;
      if (r == 1) w[7:0] = 8'h8d;
      if (r == 2) w[7:0] = 8'h05;
      apb(12'(r * 4), 1'b1, w);
      chk(32'(err), 32'h0, "write error");
      for (int b = 0; b < 4; b++) cfg[4*r+b] = w[8*b+:8] & 8'h9f;
    end
    checkRegs();
    apb(12'h00c, 1'b1, $random(seed));
    chk(32'(err), 32'h1, "status write accepted");
    apb(12'h010, 1'b0, 32'h0);
    chk(32'(err), 32'h1, "unmapped read accepted");
    chk(rd, 32'h0, "unmapped read data");
    // first grant may stem from a partial config, so only anchor on it
    serve();
    prev = gotSlot;
    repeat (30) begin
      nxt = prev;
      do nxt = (nxt + 1) % 12; while (!live(nxt));
      serve();
      chkGrant(nxt);
      prev = nxt;
    end
    // next live slot must be pending and visible in the status word
    nxt = prev;
    do nxt = (nxt + 1) % 12; while (!live(nxt));
    while (convReq !== 1'b1) @(posedge ref_clk);
    apb(12'h00c, 1'b0, 32'h0);
    chk(rd, (32'(nxt) << 8) | 32'h1, "status word");
    doReset();
    chk(32'(convReq), 32'h0, "request after reset");
    checkRegs();
    wrapUp();
  end
endmodule : adc_constant_trigger_program_test
